// ### design/vid_i2c_pkg.sv
// constants, field layout and states of the video buffer serial control port
// assumes a 50 MHz system clock and an open-drain two-wire bus outside
package vid_i2c_pkg;

   // fixed upper five bits of the 7-bit slave address
   localparam logic [4:0] ADDR_FIXED    = 5'h0B;
   localparam int         ADDR_FIX_HI   = 7;
   localparam int         ADDR_FIX_LO   = 3;
   localparam int         ADDR_SEL_HI   = 2;
   localparam int         ADDR_SEL_LO   = 1;
   localparam int         ADDR_RW_BIT   = 0;

   // subaddress codes of the channel registers
   localparam logic [7:0] SUB_CH_ONE    = 8'h01;
   localparam logic [7:0] SUB_CH_TWO    = 8'h02;
   localparam logic [7:0] SUB_CH_THREE  = 8'h03;
   localparam int         NUM_CH        = 3;

   // channel register field layout
   localparam int         CLAMP_LPF_HI  = 7;
   localparam int         CLAMP_LPF_LO  = 6;
   localparam int         MUX_SEL_BIT   = 5;
   localparam int         VLPF_HI       = 4;
   localparam int         VLPF_LO       = 3;
   localparam int         MODE_HI       = 2;
   localparam int         MODE_LO       = 0;

   // clamp filter codes
   localparam logic [1:0] CLAMP_500K    = 2'h0;
   localparam logic [1:0] CLAMP_2M5     = 2'h1;
   localparam logic [1:0] CLAMP_5M      = 2'h2;
   // video low-pass codes
   localparam logic [1:0] VLPF_9M       = 2'h0;
   localparam logic [1:0] VLPF_16M      = 2'h1;
   localparam logic [1:0] VLPF_35M      = 2'h2;
   localparam logic [1:0] VLPF_BYPASS   = 2'h3;
   // channel state codes
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_MUTE     = 3'h1;
   localparam logic [2:0] MODE_DC       = 3'h2;
   localparam logic [2:0] MODE_DC_SHIFT = 3'h3;
   localparam logic [2:0] MODE_AC       = 3'h4;
   localparam logic [2:0] MODE_CLAMP_LO = 3'h5;
   localparam logic [2:0] MODE_CLAMP_MD = 3'h6;
   localparam logic [2:0] MODE_CLAMP_HI = 3'h7;

   // bit counting and the unmapped read value
   localparam logic [3:0] CNT_LAST_BIT  = 4'h7;
   localparam logic [3:0] CNT_ACK_SLOT  = 4'h8;
   localparam logic [2:0] BIT_MSB       = 3'h7;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // reset levels of the synchronisers: bus lines idle high, address select pins low
   localparam logic [2:0] SYNC_HIGH     = 3'h7;
   localparam logic [2:0] SYNC_LOW      = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_SUB,
      ST_WDATA,
      ST_RDATA,
      ST_IGNORE
   } link_state_t;

endpackage

// ### design/vid_i2c_ctrl.sv
// serial control slave of a three-channel video buffer with its channel registers
// assumes scl and sda_in come straight from pins and sda is open drain outside
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////////
module vid_i2c_ctrl
   import vid_i2c_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       addr_select_hi_pin,
   input  wire logic       addr_select_lo_pin,
   output logic [7:0]      channel_one_config,
   output logic [7:0]      channel_two_config,
   output logic [7:0]      channel_three_config,
   output logic [7:0]      subaddr_sel
);
   import vid_i2c_pkg::*;

   //////////////////////////////////////////////////////////////////////////////
   // link domain: byte shifter clocked by scl, unreset like the real buffer
   logic [7:0]  shift_ff;

   always_ff @(posedge scl) begin
      shift_ff <= {shift_ff[6:0], sda_in};
   end

   //////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, three stages each
   logic [2:0]  scl_sync_ff;
   logic [2:0]  sda_sync_ff;
   logic [2:0]  hi_sync_ff;
   logic [2:0]  lo_sync_ff;
   logic        scl_lvl_ff;
   logic        sda_lvl_ff;
   logic        hi_lvl_ff;
   logic        lo_lvl_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_sync_ff <= SYNC_HIGH;
         sda_sync_ff <= SYNC_HIGH;
         hi_sync_ff  <= SYNC_LOW;
         lo_sync_ff  <= SYNC_LOW;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], scl};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
         hi_sync_ff  <= {hi_sync_ff[1:0], addr_select_hi_pin};
         lo_sync_ff  <= {lo_sync_ff[1:0], addr_select_lo_pin};
      end
   end

   wire scl_agree = (scl_sync_ff[1] == scl_sync_ff[2]);
   wire sda_agree = (sda_sync_ff[1] == sda_sync_ff[2]);
   wire hi_agree  = (hi_sync_ff[1] == hi_sync_ff[2]);
   wire lo_agree  = (lo_sync_ff[1] == lo_sync_ff[2]);

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_lvl_ff <= 1'b1;
         sda_lvl_ff <= 1'b1;
         hi_lvl_ff  <= 1'b0;
         lo_lvl_ff  <= 1'b0;
      end else begin
         scl_lvl_ff <= scl_agree ? scl_sync_ff[2] : scl_lvl_ff;
         sda_lvl_ff <= sda_agree ? sda_sync_ff[2] : sda_lvl_ff;
         hi_lvl_ff  <= hi_agree ? hi_sync_ff[2] : hi_lvl_ff;
         lo_lvl_ff  <= lo_agree ? lo_sync_ff[2] : lo_lvl_ff;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // bus events
   wire scl_new   = scl_agree ? scl_sync_ff[2] : scl_lvl_ff;
   wire sda_new   = sda_agree ? sda_sync_ff[2] : sda_lvl_ff;
   wire scl_rise  = scl_new & ~scl_lvl_ff;
   wire scl_fall  = ~scl_new & scl_lvl_ff;
   wire start_evt = scl_lvl_ff & scl_new & sda_lvl_ff & ~sda_new;
   wire stop_evt  = scl_lvl_ff & scl_new & ~sda_lvl_ff & sda_new;

   //////////////////////////////////////////////////////////////////////////////
   // protocol state
   link_state_t state_ff;
   link_state_t nxt_state;
   logic [3:0]  cnt_ff;
   logic [3:0]  nxt_cnt;
   logic        ack_ff;
   logic        nxt_ack;
   logic [7:0]  sub_ff;
   logic [7:0]  nxt_sub;
   logic [7:0]  tx_ff;
   logic [7:0]  nxt_tx;
   logic        oe_n_ff;
   logic        nxt_oe_n;
   logic        sda_out_ff;
   logic        wr_en;
   logic [7:0]  cfg_ff [NUM_CH];

   // the shifter settled at the true scl edge, well before the synced rise
   wire [7:0] rx_byte  = shift_ff;
   wire       addr_hit = (rx_byte[ADDR_FIX_HI:ADDR_FIX_LO] == ADDR_FIXED)
                         && (rx_byte[ADDR_SEL_HI] == hi_lvl_ff)
                         && (rx_byte[ADDR_SEL_LO] == lo_lvl_ff);
   wire       rd_dir   = rx_byte[ADDR_RW_BIT];
   wire       byte_end = (cnt_ff == CNT_LAST_BIT);
   wire       in_byte  = (state_ff == ST_ADDR) || (state_ff == ST_SUB)
                         || (state_ff == ST_WDATA) || (state_ff == ST_RDATA);
   wire       sub_one  = (sub_ff == SUB_CH_ONE);
   wire       sub_two  = (sub_ff == SUB_CH_TWO);
   wire       sub_thr  = (sub_ff == SUB_CH_THREE);
   wire       sub_ok   = sub_one | sub_two | sub_thr;
   wire [1:0] sub_idx  = sub_ff[1:0] - 2'h1;
   wire [7:0] rd_byte  = sub_ok ? cfg_ff[sub_idx] : READ_UNMAPPED;
   wire       tx_bit   = tx_ff[3'(BIT_MSB - cnt_ff[2:0])];

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_ack   = ack_ff;
      nxt_sub   = sub_ff;
      nxt_tx    = tx_ff;
      nxt_oe_n  = oe_n_ff;
      wr_en     = 1'b0;
      if (start_evt) begin
         nxt_state = ST_ADDR;
         nxt_cnt   = 4'h0;
         nxt_ack   = 1'b0;
         nxt_oe_n  = 1'b1;
      end else if (stop_evt) begin
         nxt_state = ST_IDLE;
         nxt_cnt   = 4'h0;
         nxt_ack   = 1'b0;
         nxt_oe_n  = 1'b1;
      end else if (scl_rise) begin
         if (cnt_ff == CNT_ACK_SLOT) begin
            nxt_cnt = 4'h0;
            nxt_ack = 1'b0;
            nxt_tx  = rd_byte;
         end else if (in_byte) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (byte_end) begin
               case (state_ff)
                  ST_ADDR: begin
                     nxt_ack   = addr_hit;
                     nxt_state = !addr_hit ? ST_IGNORE
                               : (rd_dir ? ST_RDATA : ST_SUB);
                  end
                  ST_SUB: begin
                     nxt_ack   = 1'b1;
                     nxt_sub   = rx_byte;
                     nxt_state = ST_WDATA;
                  end
                  ST_WDATA: begin
                     nxt_ack   = 1'b1;
                     wr_en     = sub_ok;
                     nxt_state = ST_IGNORE;
                  end
                  ST_RDATA: begin
                     nxt_ack   = 1'b0;
                     nxt_state = ST_IGNORE;
                  end
                  default: begin
                     nxt_state = ST_IGNORE;
                  end
               endcase
            end
         end
      end else if (scl_fall) begin
         if (cnt_ff == CNT_ACK_SLOT) begin
            nxt_oe_n = ~ack_ff;
         end else if (state_ff == ST_RDATA) begin
            nxt_oe_n = tx_bit;
         end else begin
            nxt_oe_n = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= 4'h0;
         ack_ff     <= 1'b0;
         sub_ff     <= 8'h00;
         tx_ff      <= 8'h00;
         oe_n_ff    <= 1'b1;
         sda_out_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         ack_ff     <= nxt_ack;
         sub_ff     <= nxt_sub;
         tx_ff      <= nxt_tx;
         oe_n_ff    <= nxt_oe_n;
         sda_out_ff <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // channel registers, no reset
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         always_ff @(posedge clk) begin
            if (wr_en && (sub_idx == 2'(ch))) begin
               cfg_ff[ch] <= rx_byte;
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // outputs
   assign sda_out              = sda_out_ff;
   assign sda_oe_n             = oe_n_ff;
   assign channel_one_config   = cfg_ff[0];
   assign channel_two_config   = cfg_ff[1];
   assign channel_three_config = cfg_ff[2];
   assign subaddr_sel          = sub_ff;

endmodule

// ### tb/vid_i2c_checker.sv
// port checks of the serial control slave
// assumes binding onto vid_i2c_ctrl, rst synchronous active high
`timescale 1ns/100ps
module vid_i2c_checker
   import vid_i2c_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       scl,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic [7:0] channel_one_config,
   input wire logic [7:0] channel_two_config,
   input wire logic [7:0] channel_three_config,
   input wire logic [7:0] subaddr_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_low; sda_out == 1'b0; endproperty
   a_low: assert property (p_low) else $error("sda driven high");
   property p_rst; disable iff (1'b0) rst |=> sda_oe_n && subaddr_sel == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset left sda held");
   property p_ackf; $fell(sda_oe_n) |-> !scl; endproperty
   a_ackf: assert property (p_ackf) else $error("sda pulled with scl high");
   property p_ackh; $rose(scl) && !sda_oe_n |=> !sda_oe_n [*4]; endproperty
   a_ackh: assert property (p_ackh) else $error("sda let go in scl high");
   property p_sub; $changed(subaddr_sel) |-> scl; endproperty
   a_sub: assert property (p_sub) else $error("subaddress moved off scl high");
   property p_c1; $changed(channel_one_config) |-> scl && subaddr_sel == SUB_CH_ONE; endproperty
   a_c1: assert property (p_c1) else $error("channel one written wrongly");
   property p_c2; $changed(channel_two_config) |-> scl && subaddr_sel == SUB_CH_TWO; endproperty
   a_c2: assert property (p_c2) else $error("channel two written wrongly");
   property p_c3; $changed(channel_three_config) |-> subaddr_sel == SUB_CH_THREE; endproperty
   a_c3: assert property (p_c3) else $error("channel three written wrongly");
endmodule
////////////////////////////////////////////////////////////////
bind vid_i2c_ctrl vid_i2c_checker chk (.clk(clk), .rst(rst), .scl(scl), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .channel_one_config(channel_one_config),
   .channel_two_config(channel_two_config), .channel_three_config(channel_three_config),
   .subaddr_sel(subaddr_sel));

// ### tb/vid_i2c_master.sv
// two-wire bus master model, scl push-pull, sda pulled low only
// assumes the bench resolves sda with a pull-up
`timescale 1ns/100ps
module vid_i2c_master (
   input  wire logic link_clk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_low
);
   int q_ticks = 5;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // four quarter steps; sda only moves with scl low except start and stop
   task automatic seq(input logic [3:0] lo, input logic [3:0] sc, output logic r);
      for (int k = 3; k >= 0; k--) begin
         sda_low <= lo[k];
         scl <= sc[k];
         repeat (q_ticks) @(posedge link_clk);
         if (k == 2) r = sda_in;
      end
   endtask
   task automatic start();
      logic r;
      seq(4'h3, 4'h6, r);
   endtask
   task automatic stop();
      logic r;
      seq(4'hC, 4'h7, r);
   endtask
   // byte out msb first, then release sda for the ninth bit (nack when reading)
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         seq({4{~tx[i]}}, 4'h6, r);
         rx[i] = r;
      end
      seq(4'h0, 4'h6, r);
      ack = ~r;
   endtask
endmodule

// ### tb/video_buffer_i2c_control_tb_top.sv
// self-checking bench of the serial control slave
// assumes design/ compiled first, master model and checker beside it
`timescale 1ns/100ps
module video_buffer_i2c_control_tb_top;
   import vid_i2c_pkg::*;
   logic       clk, rst, link_clk, pin_hi, pin_lo, sda_out, sda_oe_n, scl, sda_low, ak;
   logic [7:0] cfg [1:3];
   logic [7:0] ex [1:3];
   logic [7:0] sub, rx, d;
   logic [31:0] seed;
   int         error_cnt, n_compared, c;
   wire logic  sda_in = (sda_oe_n | sda_out) & ~sda_low;
   vid_i2c_ctrl dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_select_hi_pin(pin_hi), .addr_select_lo_pin(pin_lo),
      .channel_one_config(cfg[1]), .channel_two_config(cfg[2]),
      .channel_three_config(cfg[3]), .subaddr_sel(sub));
   vid_i2c_master m (.link_clk(link_clk), .sda_in(sda_in), .scl(scl), .sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #62.5 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] adr(input logic rw);
      return {ADDR_FIXED, pin_hi, pin_lo, rw};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [7:0] b, input logic e);
      m.xfer(b, rx, ak);
      check({7'h00, ak}, {7'h00, e});
   endtask
   task automatic pins(input logic h, input logic l);
      @(posedge clk);
      pin_hi <= h;
      pin_lo <= l;
      repeat (12) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] v);
      m.start();
      put(adr(1'b0), 1'b1);
      put(s, 1'b1);
      put(v, 1'b1);
      m.stop();
   endtask
   task automatic rd(input logic [7:0] s);
      m.start();
      put(adr(1'b0), 1'b1);
      put(s, 1'b1);
      m.stop();
      m.start();
      put(adr(1'b1), 1'b1);
      put(8'hFF, 1'b0);
      m.stop();
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #1900000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      {rst, pin_hi, pin_lo, error_cnt, n_compared, seed} = {3'b100, 32'd0, 32'd0, 32'h5095};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check(sub, 8'h00);
      m.xfer(8'h00, rx, ak);
      m.stop();
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         pins(seed[8], seed[9]);
         d = {i[1:0], seed[0], ~i[1:0], i[2:0]};
         c = i % 3 + 1;
         wr(c[7:0], d);
         ex[c] = d;
         check(cfg[c], d);
         check(sub, c[7:0]);
      end
      $display("test writes done");
      for (int k = 1; k <= 3; k++) begin
         m.q_ticks = (k == 1) ? 20 : 5;
         rd(k[7:0]);
         check(rx, ex[k]);
      end
      $display("test reads done");
      pins(1'b1, 1'b0);
      m.start();
      put({ADDR_FIXED, 2'b01, 1'b0}, 1'b0);
      put(SUB_CH_ONE, 1'b0);
      put(8'h5A, 1'b0);
      m.stop();
      m.start();
      put(adr(1'b0) ^ 8'h80, 1'b0);
      m.stop();
      check(cfg[1], ex[1]);
      $display("test address done");
      wr(8'h07, 8'hA5);
      rd(8'h07);
      check(rx, READ_UNMAPPED);
      check(cfg[3], ex[3]);
      check(cfg[1], ex[1]);
      m.start();
      put(adr(1'b0), 1'b1);
      put(SUB_CH_TWO, 1'b1);
      put(~d, 1'b1);
      put(d, 1'b0);
      m.stop();
      check(cfg[2], ~d);
      $display("test subaddress done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(sub, 8'h00);
      check(cfg[2], ~d);
      seed = xs(seed);
      wr(SUB_CH_THREE, seed[7:0]);
      check(cfg[3], seed[7:0]);
      $display("test reset done");
      print_verdict();
   end
endmodule
